// File: logic/rtcu_top.v
// Overview of operation
// - Left rotate: carry into bit0, bit7 out
// - Right rotate: carry into bit7, bit0 out
// - Destination clear: result goes to accumulator
// - Destination set: result back to file register
// - Only carry flag changes, others kept
`timescale 1ns/1ps
`include "rtcu_map.vh"
module rtcu_top (
    // Clock and reset
    input wire ref_clk,
    input wire rstn,
    // Instruction from decoder, valid in the first quarter
    input wire [13:0] instr,
    input wire instr_valid,
    // Register file read
    input wire [7:0] file_rdata,
    // Status flag in
    input wire carry_flag,
    // Quarter phase
    output reg [1:0] quarter,
    // Register file access
    output reg [6:0] file_addr,
    output reg file_re,
    output reg file_we,
    output reg [7:0] file_wdata,
    // Accumulator write
    output reg acc_we,
    output reg [7:0] acc_wdata,
    // Carry flag write; zero and digit carry never written
    output reg carry_we,
    output reg carry_wdata,
    // Instruction finished
    output reg done
);
    reg active;
    reg is_left;
    reg to_file;
    reg [7:0] operand;
    reg [7:0] result;
    reg carry_new;
    wire [7:0] rot_result;
    wire rot_carry;
    wire [5:0] opc;
    wire hit;

    assign opc = instr[`RTCU_OP_HI:`RTCU_OP_LO];
    assign hit = instr_valid &&
                 (opc == `RTCU_OPC_LEFT || opc == `RTCU_OPC_RIGHT);

    rtcu_rotate u_rot (
        .operand(operand),
        .carry_in(carry_flag),
        .go_left(is_left),
        .result(rot_result),
        .carry_out(rot_carry)
    );

    // Quarter counter free runs so every instruction takes four clocks
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            quarter <= `RTCU_Q1;
            active <= 1'b0;
            is_left <= 1'b0;
            to_file <= 1'b0;
            operand <= `RTCU_RST_BYTE;
            result <= `RTCU_RST_BYTE;
            carry_new <= 1'b0;
            file_addr <= `RTCU_RST_ADDR;
            file_re <= 1'b0;
            file_we <= 1'b0;
            file_wdata <= `RTCU_RST_BYTE;
            acc_we <= 1'b0;
            acc_wdata <= `RTCU_RST_BYTE;
            carry_we <= 1'b0;
            carry_wdata <= 1'b0;
            done <= 1'b0;
        end else begin
            quarter <= quarter + 2'h1;
            file_re <= 1'b0;
            file_we <= 1'b0;
            acc_we <= 1'b0;
            carry_we <= 1'b0;
            done <= 1'b0;
            case (quarter)
                `RTCU_Q1: begin
                    // Decode
                    active <= hit;
                    is_left <= (opc == `RTCU_OPC_LEFT);
                    to_file <= instr[`RTCU_DEST_BIT];
                    file_addr <= instr[`RTCU_ADDR_HI:`RTCU_ADDR_LO];
                    file_re <= hit;
                end
                `RTCU_Q2: begin
                    // Read operand
                    if (active) begin
                        operand <= file_rdata;
                    end
                end
                `RTCU_Q3: begin
                    // Compute; carry sampled here, before our own write
                    if (active) begin
                        result <= rot_result;
                        carry_new <= rot_carry;
                    end
                end
                default: begin
                    // Write destination and carry only
                    if (active) begin
                        file_we <= to_file;
                        file_wdata <= result;
                        acc_we <= !to_file;
                        acc_wdata <= result;
                        carry_we <= 1'b1;
                        carry_wdata <= carry_new;
                        done <= 1'b1;
                    end
                    active <= 1'b0;
                end
            endcase
        end
    end
endmodule

// File: logic/rtcu_map.vh
`ifndef RTCU_MAP_VH
`define RTCU_MAP_VH
// Opcode bits [13:8] with the destination bit at [7]
`define RTCU_OP_HI 13
`define RTCU_OP_LO 8
`define RTCU_DEST_BIT 7
`define RTCU_ADDR_HI 6
`define RTCU_ADDR_LO 0
`define RTCU_OPC_LEFT 6'h0d
`define RTCU_OPC_RIGHT 6'h0c
// Quarter phase codes
`define RTCU_Q1 2'h0
`define RTCU_Q2 2'h1
`define RTCU_Q3 2'h2
`define RTCU_Q4 2'h3
// Reset values
`define RTCU_RST_BYTE 8'h00
`define RTCU_RST_ADDR 7'h00
`endif

// File: logic/rtcu_rotate.v
`timescale 1ns/1ps
`include "rtcu_map.vh"
module rtcu_rotate (
    // Operand and carry in
    input wire [7:0] operand,
    input wire carry_in,
    input wire go_left,
    // Result
    output wire [7:0] result,
    output wire carry_out
);
    // Carry enters at the low end for left, high end for right
    assign result = go_left ? {operand[6:0], carry_in} :
                    {carry_in, operand[7:1]};
    assign carry_out = go_left ? operand[7] : operand[0];
endmodule

// File: test/rtcu_chk_sva.sv
`timescale 1ns/1ps
module rtcu_chk(input wire ref_clk, rstn, instr_valid, file_re, file_we,
    acc_we, carry_we, carry_wdata, done, input wire [1:0] quarter,
    input wire [13:0] instr, input wire [7:0] file_rdata);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence s_tk;
        quarter == 2'h0 && instr_valid && instr[13:9] == 5'h06;
    endsequence
    property p_l; s_tk ##0 instr[8] |->
        ##4 carry_wdata == $past(file_rdata[7], 3); endproperty
    a_l: assert property (p_l) else $error("bad");
    property p_r; s_tk ##0 !instr[8] |->
        ##4 carry_wdata == $past(file_rdata[0], 3); endproperty
    a_r: assert property (p_r) else $error("bad");
    property p_w; s_tk ##0 !instr[7] |-> ##4 acc_we && !file_we; endproperty
    a_w: assert property (p_w) else $error("bad");
    property p_f; s_tk ##0 instr[7] |-> ##4 file_we && !acc_we; endproperty
    a_f: assert property (p_f) else $error("bad");
    property p_c; carry_we |-> done && (acc_we || file_we); endproperty
    a_c: assert property (p_c) else $error("bad");
    property p_q; s_tk |=> file_re ##3 done; endproperty
    a_q: assert property (p_q) else $error("bad");
endmodule

// File: test/rtcu_rf.sv
`timescale 1ns/1ps
module rtcu_rf(input wire ref_clk, file_re, file_we,
    input wire [6:0] file_addr, input wire [7:0] file_wdata,
    output wire [7:0] file_rdata);
    reg [7:0] m [0:127];
    assign file_rdata = file_re ? m[file_addr] : ~m[file_addr];
    always @(posedge ref_clk) if (file_we) m[file_addr] <= file_wdata;
endmodule

// File: test/rtcu_tb_top.sv
`timescale 1ns/1ps
module rtcu_tb_top;
    reg ref_clk = 0, rstn = 0, instr_valid = 1, carry_flag = 0;
    reg [13:0] instr = 14'h0000;
    reg [19:0] r [0:3];
    wire [7:0] file_rdata, file_wdata, acc_wdata;
    wire [6:0] file_addr;
    wire [1:0] quarter;
    wire file_re, file_we, acc_we, carry_we, carry_wdata, done;
    integer err_count = 0, checks = 0, k;
    rtcu_top dut(.*);
    rtcu_rf pm(.*);
    initial forever #2 ref_clk = ~ref_clk;
    task chk(input [23:0] n, input [8:0] s, e); begin
        checks = checks + 1;
        if (s !== e) $display("[ERR] %s exp %h seen %h", n, e, s);
        err_count = err_count + (s !== e);
    end endtask
    task summarize; begin
        $display("err_count %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    end endtask
    initial begin
        r[0] = {2'h3, 8'h3a, 1'b1, 8'h75, 1'b0};
        r[1] = {2'h3, 8'hb9, 1'b0, 8'h72, 1'b1};
        r[2] = {2'h0, 8'he6, 1'b0, 8'h73, 1'b0};
        r[3] = {2'h1, 8'h3a, 1'b1, 8'h9d, 1'b0};
        repeat (20) @(posedge ref_clk);
        chk("rst", {7'h00, quarter}, 9'h000);
        #1 rstn = 1;
        for (k = 0; k < 4; k = k + 1) begin
            instr = {5'h06, r[k][19:18], 7'h2a};
            // Load operand after the previous write-back has landed
            @(posedge ref_clk);
            #1 pm.m[7'h2a] = r[k][17:10];
            carry_flag = r[k][9];
            repeat (3) @(posedge ref_clk);
            #1 chk("res", {r[k][18] ? file_wdata : acc_wdata,
                carry_wdata}, r[k][8:0]);
            chk("wen", {5'h00, file_we, acc_we, carry_we, done},
                {5'h00, r[k][18], !r[k][18], 2'b11});
        end
        instr = 14'h0fff;
        repeat (4) @(posedge ref_clk);
        #1 chk("ref", {8'h00, done}, 9'h000);
        rstn = 0;
        #1 chk("mrs", {6'h00, quarter, done}, 9'h000);
        rstn = 1;
        @(posedge ref_clk);
        #1 chk("mrq", {7'h00, quarter}, 9'h001);
        summarize;
    end
endmodule
bind rtcu_top rtcu_chk sva(.*);
